/* logic/xmii_pkg.sv */
`default_nettype none

package xmii_pkg;

  // ---------------------------------------------------------------
  // Interface modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_MII = 2'h0,
    MODE_RMII = 2'h1,
    MODE_RGMII = 2'h3
  } xmii_mode_e;

  // ---------------------------------------------------------------
  // Clock rates and divider counts
  // ---------------------------------------------------------------
  localparam int REF_CLK_MHZ = 100;
  localparam int MII_CLK_MHZ = 25;
  localparam int RMII_CLK_MHZ = 50;
  // Ref clock cycles per half period of each link clock
  localparam int MII_HALF_CYC = REF_CLK_MHZ / (2 * MII_CLK_MHZ);
  localparam int RMII_HALF_CYC = REF_CLK_MHZ / (2 * RMII_CLK_MHZ);
  localparam int DIV_W = 2;

  // ---------------------------------------------------------------
  // Data group layout
  // ---------------------------------------------------------------
  localparam int NIBBLE_W = 4;
  localparam int DIBIT_W = 2;
  localparam logic [1:0] UNUSED_BITS = 2'h0;

  // Terminal count of the divider for a mode
  function automatic logic [DIV_W-1:0] half_last(input xmii_mode_e mode);
    if (mode == MODE_RMII) begin
      return DIV_W'(RMII_HALF_CYC - 1);
    end
    return DIV_W'(MII_HALF_CYC - 1);
  endfunction

  // Keep the low di-bit only in RMII, the whole nibble otherwise
  function automatic logic [NIBBLE_W-1:0] lane_mask(input xmii_mode_e mode,
                                                    input logic [NIBBLE_W-1:0] d);
    if (mode == MODE_RMII) begin
      return {UNUSED_BITS, d[DIBIT_W-1:0]};
    end
    return d;
  endfunction

endpackage

`default_nettype wire

/* logic/xmii_if.sv */
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// MAC side data port pins
// ---------------------------------------------------------------
interface xmii_if;
  logic tx_clk;
  logic rx_clk;
  logic [3:0] tx_d;
  logic tx_en_ctl;
  logic [3:0] rx_d;
  logic rx_dv_ctl;
  logic crs_dv;
  logic rx_er;

  modport phy_end (
    output tx_clk,
    output rx_clk,
    input tx_d,
    input tx_en_ctl,
    output rx_d,
    output rx_dv_ctl,
    output crs_dv,
    output rx_er
  );

  modport mac_end (
    input tx_clk,
    input rx_clk,
    output tx_d,
    output tx_en_ctl,
    input rx_d,
    input rx_dv_ctl,
    input crs_dv,
    input rx_er
  );
endinterface

`default_nettype wire

/* logic/xmii_phy_port.sv */
`timescale 1ns/10ps
`default_nettype none

module xmii_phy_port (
  input wire logic ref_clk,
  input wire logic reset,
  input wire xmii_pkg::xmii_mode_e mode,
  xmii_if.phy_end port,
  output logic [3:0] tx_data,
  output logic tx_err,
  output logic tx_stb,
  output logic tx_frame_end,
  input wire logic [3:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_err,
  input wire logic medium_busy,
  output logic rx_take
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // Everything clears to zero in reset, so every pin idles low
  // and no strobe can leave before the first link period
  // Transmit pin samples from the MAC
  typedef struct packed {
    logic en_ctl;
    logic [3:0] d;
  } tx_pins_s;

  typedef struct packed {
    logic clk;
    logic [xmii_pkg::DIV_W-1:0] cnt;
    tx_pins_s s1;
    tx_pins_s s2;
    logic en_rise;
    logic en_prev;
    logic [3:0] hold_d;
    logic tx_clk_out;
    logic [3:0] rx_d;
    logic rx_dv;
    logic rx_er;
    logic rx_er_hold; // Error of the word on the pins
    logic rx_ctl;
    logic crs_dv;
    logic [3:0] up_d;
    logic up_er;
    logic up_stb;
    logic up_end;
  } phy_state_s;

  phy_state_s q;
  phy_state_s d;
  logic tick;
  logic rise;
  logic fall;
  logic tx_en_now;

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // The divider counter must hold the terminal count of both rates
  if (xmii_pkg::MII_HALF_CYC < 1 ||
      xmii_pkg::MII_HALF_CYC > (1 << xmii_pkg::DIV_W)) begin : g_mii_div_chk
    $error("divider too narrow for the slow link clock");
  end
  // A half period under one cycle cannot be made at all
  if (xmii_pkg::RMII_HALF_CYC < 1 ||
      xmii_pkg::RMII_HALF_CYC > (1 << xmii_pkg::DIV_W)) begin : g_rmii_div_chk
    $error("divider too narrow for the fast link clock");
  end
  // Pin lanes are a nibble and a di-bit wide
  if (xmii_pkg::NIBBLE_W != 4 || xmii_pkg::DIBIT_W != 2) begin : g_lane_chk
    $error("lane widths do not match the four pin data bus");
  end

  // ---------------------------------------------------------------
  // Link clock divider events
  // ---------------------------------------------------------------
  // Edge events of the clock this end makes, seen one cycle early
  always_comb begin
    tick = q.cnt == xmii_pkg::half_last(mode);
    rise = tick && !q.clk;
    fall = tick && q.clk;
    tx_en_now = q.s2.en_ctl;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.up_stb = 1'b0;
    d.up_end = 1'b0;

    // Two stage synchroniser on the transmit pins
    // The MAC times its pins from a synchronised copy of our clock,
    // so they arrive late, before our next rising edge in MII and RGMII but only before the second one in RMII
    d.s1.en_ctl = port.tx_en_ctl;
    d.s1.d = port.tx_d;
    d.s2 = q.s1;

    // Divider: 25MHz in MII and RGMII, 50MHz in RMII
    if (tick) begin
      d.cnt = '0;
      d.clk = !q.clk;
    end else begin
      d.cnt = q.cnt + xmii_pkg::DIV_W'(1);
    end
    // Transmit clock held low in RMII
    d.tx_clk_out = (mode != xmii_pkg::MODE_RMII) && d.clk;

    // Transmit capture on the rising edge of the link clock
    if (rise) begin
      d.hold_d = xmii_pkg::lane_mask(mode, q.s2.d);
      d.en_prev = tx_en_now;
      if (q.en_prev && !tx_en_now) begin
        d.up_end = 1'b1;
      end
      if (mode == xmii_pkg::MODE_RGMII) begin
        // Enable half of the control line
        d.en_rise = tx_en_now;
      end else if (tx_en_now) begin
        // Nibble or di-bit only while enable is asserted
        d.up_d = xmii_pkg::lane_mask(mode, q.s2.d);
        d.up_er = 1'b0;
        d.up_stb = 1'b1;
      end
    end

    // Error half of the control line on the falling edge
    if (fall && mode == xmii_pkg::MODE_RGMII && q.en_rise) begin
      d.up_d = q.hold_d;
      d.up_er = q.en_rise ^ tx_en_now;
      d.up_stb = 1'b1;
    end

    // Receive outputs change on the falling edge, stable at the rise
    // The user may move its inputs right after the take, so the
    // error of the word is held here for the second control half
    if (fall) begin
      d.rx_er_hold = rx_err && rx_valid;
      d.rx_d = xmii_pkg::lane_mask(mode, rx_data);
      d.rx_dv = rx_valid && (mode != xmii_pkg::MODE_RMII);
      d.rx_er = rx_err && rx_valid && (mode != xmii_pkg::MODE_RGMII);
      d.crs_dv = medium_busy && (mode == xmii_pkg::MODE_RMII);
      d.rx_ctl = rx_valid && (mode != xmii_pkg::MODE_RMII);
    end

    // Second half of the receive control line in RGMII
    if (rise && mode == xmii_pkg::MODE_RGMII) begin
      d.rx_ctl = q.rx_dv ^ q.rx_er_hold;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Pin drives, all from flip-flops
  // No pin of this port is low active
  assign port.tx_clk = q.tx_clk_out;
  assign port.rx_clk = q.clk;
  assign port.rx_d = q.rx_d;
  assign port.rx_dv_ctl = (mode == xmii_pkg::MODE_RGMII) ? q.rx_ctl : q.rx_dv;
  assign port.crs_dv = q.crs_dv;
  assign port.rx_er = q.rx_er;

  // User side
  assign tx_data = q.up_d;
  assign tx_err = q.up_er;
  assign tx_stb = q.up_stb;
  assign tx_frame_end = q.up_end;
  assign rx_take = fall; // Word taken at this edge

endmodule

`default_nettype wire

/* logic/xmii_mac_port.sv */
`timescale 1ns/10ps
`default_nettype none

module xmii_mac_port (
  input wire logic ref_clk,
  input wire logic reset,
  input wire xmii_pkg::xmii_mode_e mode,
  xmii_if.mac_end port,
  input wire logic [3:0] tx_data,
  input wire logic tx_en,
  input wire logic tx_err,
  output logic tx_take,
  output logic [3:0] rx_data,
  output logic rx_err,
  output logic rx_stb
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // Receive pin samples from the transceiver
  typedef struct packed {
    logic tx_clk;
    logic rx_clk;
    logic [3:0] d;
    logic dv_ctl;
    logic crs_dv;
    logic er;
  } rx_pins_s;

  typedef struct packed {
    rx_pins_s s1;
    rx_pins_s s2;
    rx_pins_s s3;
    logic tclk_prev;
    logic rclk_prev;
    logic [3:0] tx_d;
    logic tx_ctl;
    logic en_hold;
    logic er_hold;
    logic dv_rise;
    logic [3:0] hold_d;
    logic [3:0] up_d;
    logic up_er;
    logic up_stb;
  } mac_state_s;

  mac_state_s q;
  mac_state_s d;
  logic tclk;
  logic trise;
  logic tfall;
  logic rrise;
  logic rfall;

  // ---------------------------------------------------------------
  // Link clock edges
  // ---------------------------------------------------------------
  // RMII times transmit from the reference clock on the receive pin
  always_comb begin
    tclk = (mode == xmii_pkg::MODE_RMII) ? q.s2.rx_clk : q.s2.tx_clk;
    trise = tclk && !q.tclk_prev;
    tfall = !tclk && q.tclk_prev;
    rrise = q.s2.rx_clk && !q.rclk_prev;
    rfall = !q.s2.rx_clk && q.rclk_prev;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.up_stb = 1'b0;
    d.s1.tx_clk = port.tx_clk;
    d.s1.rx_clk = port.rx_clk;
    d.s1.d = port.rx_d;
    d.s1.dv_ctl = port.rx_dv_ctl;
    d.s1.crs_dv = port.crs_dv;
    d.s1.er = port.rx_er;
    d.s2 = q.s1;
    // Pins as they stood just before the detected clock edge
    d.s3 = q.s2;
    d.tclk_prev = tclk;
    d.rclk_prev = q.s2.rx_clk;

    // Transmit lines change on the falling edge
    if (tfall) begin
      d.tx_d = xmii_pkg::lane_mask(mode, tx_data);
      d.tx_ctl = tx_en;
      d.en_hold = tx_en;
      d.er_hold = tx_err && tx_en;
    end
    // Error half of the control line in RGMII
    if (trise && mode == xmii_pkg::MODE_RGMII) begin
      d.tx_ctl = q.en_hold ^ q.er_hold;
    end

    // Receive sampling on the rising edge
    if (rrise) begin
      d.hold_d = xmii_pkg::lane_mask(mode, q.s3.d);
      d.dv_rise = q.s3.dv_ctl;
      if (mode == xmii_pkg::MODE_MII && q.s3.dv_ctl) begin
        d.up_d = q.s3.d;
        d.up_er = q.s3.er;
        d.up_stb = 1'b1;
      end else if (mode == xmii_pkg::MODE_RMII && q.s3.crs_dv) begin
        d.up_d = xmii_pkg::lane_mask(mode, q.s3.d);
        d.up_er = q.s3.er;
        d.up_stb = 1'b1;
      end
    end
    if (rfall && mode == xmii_pkg::MODE_RGMII && q.dv_rise) begin
      d.up_d = q.hold_d;
      d.up_er = q.dv_rise ^ q.s3.dv_ctl;
      d.up_stb = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign port.tx_d = q.tx_d;
  assign port.tx_en_ctl = q.tx_ctl;
  assign tx_take = tfall;
  assign rx_data = q.up_d;
  assign rx_err = q.up_er;
  assign rx_stb = q.up_stb;

endmodule

`default_nettype wire

/* testbench/xmii_link_assertions.sv */
`timescale 1ns/10ps
`default_nettype none

module xmii_link_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire xmii_pkg::xmii_mode_e mode,
  input wire logic tx_clk,
  input wire logic rx_clk,
  input wire logic [3:0] tx_d,
  input wire logic tx_en_ctl,
  input wire logic [3:0] rx_d,
  input wire logic rx_dv_ctl,
  input wire logic crs_dv,
  input wire logic rx_er
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ---------------------------------------------------------------
  // Clock shapes
  // ---------------------------------------------------------------
  // Rest of a 25MHz period after a rising edge
  sequence s_slow_rest(logic c);
    c ##1 !c [*2] ##1 c;
  endsequence

  // Rest of a 50MHz period after a rising edge
  sequence s_fast_rest(logic c);
    !c ##1 c;
  endsequence

  // ---------------------------------------------------------------
  // Link checks
  // ---------------------------------------------------------------
  a_mii_txclk_rate: assert property (
    mode == xmii_pkg::MODE_MII && $rose(tx_clk) |=> s_slow_rest(tx_clk))
    else $error("transmit clock period wrong");
  a_rmii_refclk_rate: assert property (
    mode == xmii_pkg::MODE_RMII && $rose(rx_clk) |=> s_fast_rest(rx_clk))
    else $error("reference clock period wrong");
  a_rmii_txclk_idle: assert property (mode == xmii_pkg::MODE_RMII |-> !tx_clk)
    else $error("transmit clock runs in RMII");
  a_rmii_txd_ground: assert property (
    mode == xmii_pkg::MODE_RMII |-> tx_d[3:2] == 2'h0)
    else $error("upper transmit bits not grounded");
  a_rmii_rxd_unused: assert property (
    mode == xmii_pkg::MODE_RMII |-> rx_d[3:2] == 2'h0)
    else $error("upper receive bits used in RMII");
  a_crs_rmii_only: assert property (mode != xmii_pkg::MODE_RMII |-> !crs_dv)
    else $error("carrier sense outside RMII");
  a_rxd_change_fall: assert property (!$stable(rx_d) |-> $fell(rx_clk))
    else $error("receive data moved off the falling clock");
  a_mii_err_valid: assert property (
    mode == xmii_pkg::MODE_MII && rx_er |-> rx_dv_ctl)
    else $error("receive error without valid");
endmodule

`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  typedef struct packed {
    xmii_pkg::xmii_mode_e m;
    logic [15:0] d;
    logic [3:0] e;
  } row_s;

  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  xmii_pkg::xmii_mode_e mode = xmii_pkg::MODE_MII;
  logic [3:0] ptx_data, mrx_data, prx_data = 4'h0, mtx_data = 4'h0;
  logic ptx_err, ptx_stb, ptx_end, rx_take, tx_take, mrx_err, mrx_stb;
  logic prx_valid = 1'b0, prx_err = 1'b0, busy = 1'b0, mtx_en = 1'b0, mtx_err = 1'b0;
  logic [4:0] exp_v;
  logic [4:0] eq_tx[$];
  logic [4:0] eq_rx[$];
  int n_errors = 0;
  int checks = 0;
  int n_end = 0;
  row_s rows[4] = '{'{xmii_pkg::MODE_MII, 16'h5a3c, 4'h5},
                    '{xmii_pkg::MODE_RMII, 16'hfc3e, 4'h0},
                    '{xmii_pkg::MODE_RGMII, 16'h81e7, 4'ha},
                    '{xmii_pkg::MODE_MII, 16'hf00f, 4'h0}};

  // Free running clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  xmii_if link ();
  xmii_phy_port xmii_phy_port_i (.ref_clk(ref_clk), .reset(reset), .mode(mode),
    .port(link.phy_end), .tx_data(ptx_data), .tx_err(ptx_err), .tx_stb(ptx_stb),
    .tx_frame_end(ptx_end), .rx_data(prx_data), .rx_valid(prx_valid), .rx_err(prx_err),
    .medium_busy(busy), .rx_take(rx_take));
  xmii_mac_port xmii_mac_port_i (.ref_clk(ref_clk), .reset(reset), .mode(mode),
    .port(link.mac_end), .tx_data(mtx_data), .tx_en(mtx_en), .tx_err(mtx_err),
    .tx_take(tx_take), .rx_data(mrx_data), .rx_err(mrx_err), .rx_stb(mrx_stb));
  xmii_link_checker xmii_link_checker_i (.ref_clk(ref_clk), .reset(reset), .mode(mode),
    .tx_clk(link.tx_clk), .rx_clk(link.rx_clk), .tx_d(link.tx_d),
    .tx_en_ctl(link.tx_en_ctl), .rx_d(link.rx_d), .rx_dv_ctl(link.rx_dv_ctl),
    .crs_dv(link.crs_dv), .rx_er(link.rx_er));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task cmp(input logic [4:0] got, input logic [4:0] want, input string what);
    checks++;
    if (got !== want) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  task do_reset(input xmii_pkg::xmii_mode_e m);
    @(negedge ref_clk);
    reset = 1'b1;
    mode = m;
    n_end = 0;
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
  endtask

  // One transmit item, held until the MAC end takes it
  task tx_item(input logic en, input logic [3:0] d, input logic e);
    mtx_en = en;
    mtx_data = d;
    mtx_err = e;
    if (en) eq_tx.push_back({mode == xmii_pkg::MODE_RGMII ? e : 1'b0,
                             mode == xmii_pkg::MODE_RMII ? {2'h0, d[1:0]} : d});
    for (int w = 0; w < 20 && tx_take !== 1'b1; w++) @(negedge ref_clk);
    @(negedge ref_clk);
  endtask

  // One receive item, held until the PHY end takes it
  task rx_item(input logic v, input logic [3:0] d, input logic e);
    prx_data = d;
    prx_valid = v;
    prx_err = e & v;
    busy = v;
    if (v) eq_rx.push_back({e, mode == xmii_pkg::MODE_RMII ? {2'h0, d[1:0]} : d});
    for (int w = 0; w < 20 && rx_take !== 1'b1; w++) @(negedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Four-item frame each way, then idle items
  task run_row(input row_s r);
    do_reset(r.m);
    fork
      for (int k = 0; k < 6; k++) tx_item(k < 4, r.d[(k % 4) * 4 +: 4], r.e[k % 4] & (k < 4));
      for (int k = 0; k < 6; k++) rx_item(k < 4, r.d[(k % 4) * 4 +: 4], r.e[k % 4]);
    join
    repeat (24) @(negedge ref_clk);
    cmp(5'(eq_tx.size()), 5'h00, "transmit items lost");
    cmp(5'(eq_rx.size()), 5'h00, "receive items lost");
    cmp(5'(n_end), 5'h01, "frame end count");
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Every strobe against the oldest expected item
  always @(negedge ref_clk) begin
    if (ptx_end === 1'b1) begin
      n_end++;
    end
    if (ptx_stb === 1'b1) begin
      exp_v = (eq_tx.size() > 0) ? eq_tx.pop_front() : 'x;
      cmp({ptx_err, ptx_data}, exp_v, "phy transmit item");
    end
    if (mrx_stb === 1'b1) begin
      exp_v = (eq_rx.size() > 0) ? eq_rx.pop_front() : 'x;
      cmp({mrx_err, mrx_data}, exp_v, "mac receive item");
    end
  end

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    for (int r = 0; r < 4; r++) begin
      run_row(rows[r]);
      $display("row %0d done", r);
    end
    do_reset(xmii_pkg::MODE_MII);
    tx_item(1'b1, 4'h6, 1'b0);
    tx_item(1'b1, 4'h9, 1'b0);
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    cmp({link.tx_en_ctl, link.tx_d}, 5'h00, "transmit pins in reset");
    cmp({ptx_stb, mrx_stb, link.rx_dv_ctl, link.crs_dv, link.rx_er}, 5'h00, "reset outputs");
    eq_tx.delete();
    eq_rx.delete();
    run_row(rows[2]);
    $display("mid frame reset done");
    finish_test();
  end

  // Hang guard
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
endmodule

`default_nettype wire
